// ===== pd_device.sv
// Operation
// - Halt enters sleep or software standby by select
// - Standby select survives wake-up, software clears it
// - Bits seven to four steer power-down, bit two picks the NMI wake edge
// - Settle code decodes to listed state counts
// - Flash variant: code 101 gives 1,024
// - Settling: oscillator runs, core and peripherals wait
// - Sleep halts core, peripherals keep running
// - Accepted interrupt ends sleep, starts handling
// - Disabled or masked interrupts cannot wake
// - Init pin low in sleep gives reset
// - Powerdown pin low in sleep: hardware standby
// - Software standby stops clock, core, peripherals
// - Standby resets peripherals, keeps core and RAM
// - Standby wake sources start oscillator, settle, resume
// - Software disables interrupts 3,4,5,7 before standby
// - Init low starts oscillator, rise starts reset
// - Powerdown pin low in standby: hardware standby
// - Software picks settle code for 8 ms
// - Short code set late, restored after wake
// - Edge select picks falling or rising NMI
// - Ports hold their outputs in software standby
// - Powerdown pin low always: hardware standby
// - Powerdown rise starts oscillator, init rise resets
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module pd_device
    import pd_pkg::*;
#(
    parameter int SETTLE_BASE = SETTLE_BASE_DEF,
    parameter bit FLASH_VARIANT = 1'b1
)
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    pd_if.device bus,
    output logic o_periph_clk_en,
    output logic o_periph_rst,
    output logic o_osc_run,
    output logic o_io_hold,
    output logic o_io_hiz,
    output logic o_ram_enable,
    output logic o_host_if_enable
);

    // ****************************************
    // Declarations
    // ****************************************
    pd_state_t state_r;
    pd_state_t state_nxt;
    logic [7:0] sys_ctrl_r;
    logic nmi_prev_r;
    logic mask_at_halt_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] target;
    logic settle_done;
    logic nmi_event;
    logic [7:0] ext_req;
    logic sleep_wake;
    logic hw_powerdown_n_wake;
    logic reg_hit;

    localparam logic [CNT_W-1:0] BASE_CNT = CNT_W'(SETTLE_BASE);
    localparam logic [CNT_W-1:0] SHORT_CNT = CNT_W'(SETTLE_SHORT);

    // ****************************************
    // Settle count decode
    // ****************************************
    function automatic logic [CNT_W-1:0] settle_target(input logic [2:0] code);
        logic [CNT_W-1:0] t;
        t = BASE_CNT << 4;
        if (!code[2] && !code[1] && !code[0])
            t = BASE_CNT;
        else if (!code[2] && !code[1])
            t = BASE_CNT << 1;
        else if (!code[2] && !code[0])
            t = BASE_CNT << 2;
        else if (!code[2])
            t = BASE_CNT << 3;
        else if (FLASH_VARIANT && code == SETTLE_CODE_SHORT)
            t = SHORT_CNT;
        return t;
    endfunction

    assign target = settle_target(sys_ctrl_r[SETTLE_HI:SETTLE_LO]);
    assign settle_done = (cnt_r == target - 1'b1);
    assign reg_hit = (bus.reg_addr == SYS_CTRL_ADDR);

    // ****************************************
    // Wake sources
    // ****************************************
    // Edge of the NMI pin as chosen by the edge select bit
    assign nmi_event = sys_ctrl_r[NMI_EDGE_BIT] ? (bus.nmi_n & ~nmi_prev_r)
                                                : (~bus.nmi_n & nmi_prev_r);
    assign ext_req = bus.ext_irq_req & bus.ext_int_en;
    // Mask flag captured at halt leaves only NMI able to wake
    assign sleep_wake = nmi_event | (~mask_at_halt_r
                        & ((|ext_req) | (bus.periph_irq & bus.periph_irq_en)));
    assign hw_powerdown_n_wake = nmi_event | (|(ext_req & SWSTBY_WAKE_MASK));

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        state_nxt = state_r;
        if (!bus.hw_powerdown_n)
            state_nxt = ST_HW_HW_POWERDOWN_N;
        else if (!bus.chip_init_n)
            state_nxt = ST_RESET;
        else
        begin
            unique case (state_r)
                ST_RUN:
                begin
                    if (bus.halt)
                        state_nxt = sys_ctrl_r[HW_POWERDOWN_N_SEL_BIT] ? ST_SW_HW_POWERDOWN_N : ST_SLEEP;
                end
                ST_SLEEP:
                begin
                    if (sleep_wake)
                        state_nxt = ST_RUN;
                end
                ST_SW_HW_POWERDOWN_N:
                begin
                    if (hw_powerdown_n_wake)
                        state_nxt = ST_SETTLE;
                end
                ST_SETTLE:
                begin
                    if (settle_done)
                        state_nxt = ST_RUN;
                end
                ST_HW_HW_POWERDOWN_N:
                begin
                    state_nxt = ST_RESET;
                end
                ST_RESET:
                begin
                    state_nxt = ST_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            state_r <= ST_RESET;
        else
            state_r <= state_nxt;
    end

    // ****************************************
    // Settling counter on the oscillator clock
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            cnt_r <= '0;
        else if ((state_r == ST_SETTLE || state_r == ST_RESET) && !settle_done)
            cnt_r <= cnt_r + 1'b1;
        else if (state_r != ST_SETTLE && state_r != ST_RESET)
            cnt_r <= '0;
    end

    // ****************************************
    // Oscillator stable flag
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            bus.osc_stable <= 1'b0;
        else if (state_r == ST_SW_HW_POWERDOWN_N || state_r == ST_HW_HW_POWERDOWN_N)
            bus.osc_stable <= 1'b0;
        else if (settle_done)
            bus.osc_stable <= 1'b1;
    end

    // ****************************************
    // Halt capture and NMI history
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            mask_at_halt_r <= 1'b0;
            nmi_prev_r <= 1'b1;
        end
        else
        begin
            nmi_prev_r <= bus.nmi_n;
            if (state_r == ST_RUN && bus.halt)
                mask_at_halt_r <= bus.irq_mask_flag;
        end
    end

    // ****************************************
    // System control register, write side
    // ****************************************
    // Wake-up never touches the select bit; only writes, reset and hardware standby change it
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            sys_ctrl_r <= SYS_CTRL_RST;
        else if (state_r == ST_RESET || state_r == ST_HW_HW_POWERDOWN_N)
            sys_ctrl_r <= SYS_CTRL_RST;
        else if (bus.reg_wr && reg_hit)
            sys_ctrl_r <= (bus.reg_wdata & SYS_CTRL_WMASK)
                        | (sys_ctrl_r & ~SYS_CTRL_WMASK);
    end

    // ****************************************
    // System control register, read side
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            bus.reg_rdata <= 8'h00;
        else if (bus.reg_rd && reg_hit)
            bus.reg_rdata <= sys_ctrl_r;
        else
            bus.reg_rdata <= 8'h00;
    end

    // ****************************************
    // Event pulses toward the core
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            bus.irq_start <= 1'b0;
            bus.reset_start <= 1'b0;
        end
        else
        begin
            bus.irq_start <= (state_r == ST_SLEEP || state_r == ST_SETTLE)
                           && state_nxt == ST_RUN;
            bus.reset_start <= state_r == ST_RESET && state_nxt == ST_RUN;
        end
    end

    // ****************************************
    // Mode outputs, registered from next state
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            bus.mode <= ST_RESET;
            bus.cpu_halt <= 1'b1;
            bus.cpu_clk_en <= 1'b0;
            o_periph_clk_en <= 1'b0;
            o_periph_rst <= 1'b1;
            o_osc_run <= 1'b1;
            o_io_hold <= 1'b0;
            o_io_hiz <= 1'b0;
        end
        else
        begin
            bus.mode <= state_nxt;
            bus.cpu_halt <= state_nxt != ST_RUN;
            bus.cpu_clk_en <= state_nxt == ST_RUN || state_nxt == ST_SLEEP;
            o_periph_clk_en <= state_nxt == ST_RUN || state_nxt == ST_SLEEP;
            o_periph_rst <= state_nxt == ST_SW_HW_POWERDOWN_N || state_nxt == ST_HW_HW_POWERDOWN_N
                          || state_nxt == ST_RESET;
            o_osc_run <= state_nxt != ST_SW_HW_POWERDOWN_N && state_nxt != ST_HW_HW_POWERDOWN_N;
            o_io_hold <= state_nxt == ST_SW_HW_POWERDOWN_N || state_nxt == ST_SETTLE;
            o_io_hiz <= state_nxt == ST_HW_HW_POWERDOWN_N;
        end
    end

    // ****************************************
    // Other function bits, stored only
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_ram_enable <= 1'b1;
            o_host_if_enable <= 1'b0;
        end
        else
        begin
            o_ram_enable <= sys_ctrl_r[RAM_EN_BIT];
            o_host_if_enable <= sys_ctrl_r[HOST_IF_BIT];
        end
    end

endmodule

`default_nettype wire

// ===== pd_pkg.sv
package pd_pkg;

    // ****************************************
    // System control register
    // ****************************************
    localparam logic [15:0] SYS_CTRL_ADDR = 16'hffc4;
    localparam logic [7:0] SYS_CTRL_RST = 8'h09;
    localparam logic [7:0] SYS_CTRL_WMASK = 8'hf7;  // Flag bit 3 is read only
    localparam int HW_POWERDOWN_N_SEL_BIT = 7;
    localparam int SETTLE_HI = 6;
    localparam int SETTLE_LO = 4;
    localparam int NMI_EDGE_BIT = 2;
    localparam int HOST_IF_BIT = 1;
    localparam int RAM_EN_BIT = 0;

    // ****************************************
    // Settling counts in clock states
    // ****************************************
    localparam int SETTLE_BASE_DEF = 8192;
    localparam int SETTLE_SHORT = 1024;
    localparam int CNT_W = 18;
    localparam logic [2:0] SETTLE_CODE_SHORT = 3'h5;

    // ****************************************
    // External interrupt groups
    // ****************************************
    localparam logic [7:0] SWSTBY_WAKE_MASK = 8'h47;
    localparam logic [7:0] HW_POWERDOWN_N_DIS_MASK = 8'hb8;

    // ****************************************
    // Controller registers
    // ****************************************
    localparam logic [3:0] HOST_CTRL = 4'h0;
    localparam logic [3:0] HOST_EXT_REQ = 4'h1;
    localparam logic [3:0] HOST_EXT_EN = 4'h2;
    localparam logic [3:0] HOST_SYS_WR = 4'h3;
    localparam logic [3:0] HOST_SYS_RD = 4'h4;
    localparam logic [3:0] HOST_STATUS = 4'h5;
    localparam logic [3:0] HOST_EVENTS = 4'h6;
    localparam logic [7:0] HOST_CTRL_RST = 8'h4c;
    localparam int CTRL_HALT_BIT = 0;
    localparam int CTRL_MASK_BIT = 1;
    localparam int CTRL_INIT_BIT = 2;
    localparam int CTRL_PD_BIT = 3;
    localparam int CTRL_PIRQ_BIT = 4;
    localparam int CTRL_PIRQ_EN_BIT = 5;
    localparam int CTRL_NMI_BIT = 6;

    // ****************************************
    // Power-down states
    // ****************************************
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_SLEEP = 6'h02,
        ST_SW_HW_POWERDOWN_N = 6'h04,
        ST_SETTLE = 6'h08,
        ST_HW_HW_POWERDOWN_N = 6'h10,
        ST_RESET = 6'h20
    } pd_state_t;

endpackage

// ===== pd_if.sv
`timescale 1ns/10ps
`default_nettype none

interface pd_if;

    // ****************************************
    // Core and pin side, driven by the controller
    // ****************************************
    logic halt;
    logic irq_mask_flag;
    logic periph_irq;
    logic periph_irq_en;
    logic nmi_n;
    logic [7:0] ext_irq_req;
    logic [7:0] ext_int_en;
    logic chip_init_n;
    logic hw_powerdown_n;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;

    // ****************************************
    // Answers from the power-down device
    // ****************************************
    logic [7:0] reg_rdata;
    logic cpu_halt;
    logic cpu_clk_en;
    logic osc_stable;
    logic irq_start;
    logic reset_start;
    logic [5:0] mode;

    modport device (
        input halt, irq_mask_flag, periph_irq, periph_irq_en, nmi_n, ext_irq_req,
        input ext_int_en, chip_init_n, hw_powerdown_n, reg_addr, reg_wdata, reg_wr, reg_rd,
        output reg_rdata, cpu_halt, cpu_clk_en, osc_stable, irq_start, reset_start, mode
    );

    modport host (
        output halt, irq_mask_flag, periph_irq, periph_irq_en, nmi_n, ext_irq_req,
        output ext_int_en, chip_init_n, hw_powerdown_n, reg_addr, reg_wdata, reg_wr, reg_rd,
        input reg_rdata, cpu_halt, cpu_clk_en, osc_stable, irq_start, reset_start, mode
    );

endinterface

`default_nettype wire

// ===== pd_host.sv
`timescale 1ns/10ps
`default_nettype none

module pd_host
    import pd_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    pd_if.host bus
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] ctrl_r;
    logic [7:0] ext_req_r;
    logic [7:0] ext_en_r;
    logic [7:0] sys_wdata_r;
    logic [7:0] sys_rd_r;
    logic [1:0] events_r;
    logic standby_select_shadow_r;
    logic halt_pend_r;
    logic halt_r;
    logic sys_wr_r;
    logic sys_rd_req_r;
    logic sys_rd_pend_r;
    logic init_out_r;

    // ****************************************
    // Pins and core lines
    // ****************************************
    assign bus.halt = halt_r;
    assign bus.irq_mask_flag = ctrl_r[CTRL_MASK_BIT];
    assign bus.periph_irq = ctrl_r[CTRL_PIRQ_BIT];
    assign bus.periph_irq_en = ctrl_r[CTRL_PIRQ_EN_BIT];
    assign bus.nmi_n = ctrl_r[CTRL_NMI_BIT];
    assign bus.hw_powerdown_n = ctrl_r[CTRL_PD_BIT];
    assign bus.chip_init_n = init_out_r;
    assign bus.ext_irq_req = ext_req_r;
    assign bus.ext_int_en = ext_en_r;
    assign bus.reg_addr = SYS_CTRL_ADDR;
    assign bus.reg_wdata = sys_wdata_r;
    assign bus.reg_wr = sys_wr_r;
    assign bus.reg_rd = sys_rd_req_r;

    // ****************************************
    // Control and interrupt registers
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            ctrl_r <= HOST_CTRL_RST;
            ext_req_r <= 8'h00;
            ext_en_r <= 8'h00;
        end
        else if (i_wr && i_addr == HOST_CTRL)
        begin
            ctrl_r <= i_wdata & ~(8'h01 << CTRL_HALT_BIT);
            if (i_wdata[CTRL_HALT_BIT] && standby_select_shadow_r)
                ext_en_r <= ext_en_r & ~HW_POWERDOWN_N_DIS_MASK;
        end
        else if (i_wr && i_addr == HOST_EXT_REQ)
            ext_req_r <= i_wdata;
        else if (i_wr && i_addr == HOST_EXT_EN)
            ext_en_r <= i_wdata;
    end

    // ****************************************
    // Halt request, one cycle after the enables
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            halt_pend_r <= 1'b0;
            halt_r <= 1'b0;
        end
        else
        begin
            halt_pend_r <= i_wr && i_addr == HOST_CTRL && i_wdata[CTRL_HALT_BIT];
            halt_r <= halt_pend_r;
        end
    end

    // ****************************************
    // Init pin held low until the oscillator settles
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            init_out_r <= 1'b1;
        else if (!ctrl_r[CTRL_INIT_BIT])
            init_out_r <= 1'b0;
        else if (bus.osc_stable)
            init_out_r <= 1'b1;
    end

    // ****************************************
    // Device register access
    // ****************************************
    // Settle code choice is left to software as written
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            sys_wr_r <= 1'b0;
            sys_rd_req_r <= 1'b0;
            sys_rd_pend_r <= 1'b0;
            sys_wdata_r <= 8'h00;
            sys_rd_r <= 8'h00;
            standby_select_shadow_r <= 1'b0;
        end
        else
        begin
            sys_wr_r <= i_wr && i_addr == HOST_SYS_WR;
            sys_rd_req_r <= i_wr && i_addr == HOST_SYS_RD;
            sys_rd_pend_r <= sys_rd_req_r;
            if (i_wr && i_addr == HOST_SYS_WR)
            begin
                sys_wdata_r <= i_wdata;
                standby_select_shadow_r <= i_wdata[HW_POWERDOWN_N_SEL_BIT];
            end
            if (sys_rd_pend_r)
                sys_rd_r <= bus.reg_rdata;
        end
    end

    // ****************************************
    // Sticky event flags, set wins over read clear
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            events_r <= 2'h0;
        else
            events_r <= ((i_rd && i_addr == HOST_EVENTS) ? 2'h0 : events_r)
                      | {bus.reset_start, bus.irq_start};
    end

    // ****************************************
    // Read data, one cycle after the strobe
    // ****************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_rdata <= 8'h00;
        else if (!i_rd)
            o_rdata <= 8'h00;
        else
        begin
            unique case (i_addr)
                HOST_CTRL: o_rdata <= ctrl_r;
                HOST_EXT_REQ: o_rdata <= ext_req_r;
                HOST_EXT_EN: o_rdata <= ext_en_r;
                HOST_SYS_RD: o_rdata <= sys_rd_r;
                HOST_STATUS: o_rdata <= {bus.cpu_halt, bus.osc_stable, bus.mode};
                HOST_EVENTS: o_rdata <= {6'h00, events_r};
                default: o_rdata <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== pd_checker.sv
`timescale 1ns/10ps
`default_nettype none

module pd_checker
    import pd_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic halt,
    input wire logic irq_mask_flag,
    input wire logic nmi_n,
    input wire logic [7:0] ext_irq_req,
    input wire logic [7:0] ext_int_en,
    input wire logic chip_init_n,
    input wire logic hw_powerdown_n,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic cpu_halt,
    input wire logic cpu_clk_en,
    input wire logic irq_start,
    input wire logic reset_start,
    input wire logic [5:0] mode
);
    logic sel_r;
    logic mask_r;
    logic pins_hi;

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    assign pins_hi = chip_init_n && hw_powerdown_n;

    // Shadow of standby select and of the mask at halt
    always_ff @(posedge i_sys_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            sel_r <= 1'b0;
            mask_r <= 1'b0;
        end
        else
        begin
            if (mode == 6'h20 || mode == 6'h10) sel_r <= 1'b0;
            else if (reg_wr && reg_addr == SYS_CTRL_ADDR) sel_r <= reg_wdata[HW_POWERDOWN_N_SEL_BIT];
            if (halt && mode == 6'h01) mask_r <= irq_mask_flag;
        end
    end

    // ****************************************
    // Mode transitions
    // ****************************************
    sequence s_settle_entry;
        mode == 6'h04 ##1 mode == 6'h08;
    endsequence

    hw_hw_powerdown_n_entry_a: assert property (!hw_powerdown_n |=> mode == 6'h10)
        else $error("powerdown pin not obeyed");
    init_reset_a: assert property (hw_powerdown_n && !chip_init_n |=> mode == 6'h20)
        else $error("init pin not obeyed");
    halt_target_a: assert property (mode == 6'h01 && halt && pins_hi |=> mode == (sel_r ? 6'h04 : 6'h02))
        else $error("halt went to wrong mode");
    sleep_core_a: assert property (mode == 6'h02 |-> cpu_halt && cpu_clk_en)
        else $error("sleep core or clock wrong");
    hw_powerdown_n_clock_a: assert property (mode == 6'h04 |-> cpu_halt && !cpu_clk_en)
        else $error("standby clock not stopped");
    masked_sleep_a: assert property (mode == 6'h02 && mask_r && pins_hi && $stable(nmi_n) |=> mode == 6'h02)
        else $error("masked sleep woke");
    hw_powerdown_n_wake_a: assert property (mode == 6'h04 && pins_hi && |(ext_irq_req & ext_int_en & SWSTBY_WAKE_MASK) |=> mode == 6'h08)
        else $error("standby wake missed");
    settle_hold_a: assert property (s_settle_entry |-> (cpu_halt && !cpu_clk_en && mode == 6'h08)[*8])
        else $error("settling cut short");
    wake_pulse_a: assert property (irq_start |-> mode == 6'h01 && ($past(mode) == 6'h02 || $past(mode) == 6'h08))
        else $error("stray interrupt start");
    reset_pulse_a: assert property (reset_start |-> mode == 6'h01 && $past(mode) == 6'h20)
        else $error("stray reset start");
endmodule

`default_nettype wire

// ===== tb_power_down_mode_controller.sv
`timescale 1ns/10ps
`default_nettype none

module tb_power_down_mode_controller
    import pd_pkg::*;
;
    logic i_sys_clk;
    logic i_sys_rst;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [7:0] o_rdata;
    logic osc_run, periph_rst, io_hold, io_hiz, pclk_en, ram_en, host_en;
    logic [15:0] want;
    int miscompares;
    int checked;
    int n;

    pd_if i_pd_if ();
    pd_device #(.SETTLE_BASE(16), .FLASH_VARIANT(1'b1)) i_pd_device (.i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst), .bus(i_pd_if), .o_periph_clk_en(pclk_en),
        .o_periph_rst(periph_rst), .o_osc_run(osc_run), .o_io_hold(io_hold),
        .o_io_hiz(io_hiz), .o_ram_enable(ram_en), .o_host_if_enable(host_en));
    pd_host i_pd_host (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .bus(i_pd_if));
    pd_checker i_pd_checker (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .halt(i_pd_if.halt),
        .irq_mask_flag(i_pd_if.irq_mask_flag), .nmi_n(i_pd_if.nmi_n),
        .ext_irq_req(i_pd_if.ext_irq_req), .ext_int_en(i_pd_if.ext_int_en),
        .chip_init_n(i_pd_if.chip_init_n), .hw_powerdown_n(i_pd_if.hw_powerdown_n),
        .reg_addr(i_pd_if.reg_addr), .reg_wdata(i_pd_if.reg_wdata), .reg_wr(i_pd_if.reg_wr),
        .cpu_halt(i_pd_if.cpu_halt), .cpu_clk_en(i_pd_if.cpu_clk_en),
        .irq_start(i_pd_if.irq_start), .reset_start(i_pd_if.reset_start), .mode(i_pd_if.mode));

    // Free-running system clock
    always #5 i_sys_clk = ~i_sys_clk;

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    // Host register read, data taken in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk({8'h00, o_rdata}, {8'h00, exp});
        @(posedge i_sys_clk);
    endtask

    // Device register read through the host, four cycles of capture time
    task automatic sys_chk(input logic [7:0] exp);
        wr(HOST_SYS_RD, 8'h00);
        repeat (2) @(posedge i_sys_clk);
        rd_chk(HOST_SYS_RD, exp);
    endtask

    // Bounded wait for a mode, checked at the falling edge
    task automatic seek(input logic [5:0] m);
        int k;
        k = 0;
        do
        begin
            @(negedge i_sys_clk);
            k++;
        end
        while (i_pd_if.mode !== m && k < 3000);
        chk({10'h000, i_pd_if.mode}, {10'h000, m});
        if (i_pd_if.mode !== m) tally_and_finish();
        @(posedge i_sys_clk);
    endtask

    // Cycles spent settling after a standby wake
    task automatic settle(output int cnt);
        int k;
        k = 0;
        cnt = 0;
        while (i_pd_if.mode !== 6'h08 && k < 3000)
        begin
            @(negedge i_sys_clk);
            k++;
        end
        while (i_pd_if.mode === 6'h08 && cnt < 3000)
        begin
            @(negedge i_sys_clk);
            cnt++;
        end
        @(posedge i_sys_clk);
    endtask

    // Main sequence
    initial
    begin
        i_sys_clk = 1'b0;
        i_sys_rst = 1'b1;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        miscompares = 0;
        checked = 0;
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_sys_clk);
        seek(6'h01);
        rd_chk(HOST_EVENTS, 8'h02);
        sys_chk(8'h09);
        chk({14'h0000, ram_en, host_en}, 16'h0002);
        wr(HOST_SYS_WR, 8'h00);
        sys_chk(8'h08);
        chk({14'h0000, ram_en, host_en}, 16'h0000);
        wr(HOST_EXT_EN, 8'h01);
        wr(HOST_CTRL, 8'h4d);
        seek(6'h02);
        wr(HOST_EXT_REQ, 8'h01);
        seek(6'h01);
        wr(HOST_EXT_REQ, 8'h00);
        wr(HOST_CTRL, 8'h4f);
        seek(6'h02);
        wr(HOST_EXT_REQ, 8'h01);
        repeat (5) @(posedge i_sys_clk);
        seek(6'h02);
        wr(HOST_CTRL, 8'h0e);
        seek(6'h01);
        wr(HOST_EXT_REQ, 8'h00);
        wr(HOST_CTRL, 8'h4c);
        for (int c = 0; c < 7; c++)
        begin
            want = (c == 5) ? 16'h0400 : 16'h0010 << ((c > 4) ? 4 : c);
            wr(HOST_SYS_WR, {1'b1, c[2:0], 4'h0});
            wr(HOST_CTRL, 8'h4d);
            seek(6'h04);
            @(negedge i_sys_clk);
            chk({11'h000, pclk_en, osc_run, periph_rst, io_hold, io_hiz}, 16'h0006);
            @(posedge i_sys_clk);
            wr(HOST_EXT_REQ, 8'h01);
            settle(n);
            chk(n[15:0], want);
            wr(HOST_EXT_REQ, 8'h00);
            sys_chk({1'b1, c[2:0], 4'h8});
        end
        wr(HOST_SYS_WR, 8'h84);
        wr(HOST_CTRL, 8'h0c);
        wr(HOST_CTRL, 8'h0d);
        seek(6'h04);
        wr(HOST_CTRL, 8'h4c);
        seek(6'h08);
        seek(6'h01);
        for (int k = 0; k < 4; k++)
        begin
            wr(HOST_SYS_WR, {k[0], 7'h00});
            wr(HOST_CTRL, 8'h4d);
            seek(k[0] ? 6'h04 : 6'h02);
            wr(HOST_CTRL, k[1] ? 8'h44 : 8'h48);
            seek(k[1] ? 6'h10 : 6'h20);
            wr(HOST_CTRL, 8'h48);
            seek(6'h20);
            wr(HOST_CTRL, 8'h4c);
            seek(6'h01);
        end
        tally_and_finish();
    end
endmodule

`default_nettype wire
